// ==== sim/pib_periph_model.sv ====
`timescale 1ns/10ps
module pib_periph_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [23:0] fire,
  output logic [7:0] event_a,
  output logic [7:0] event_b,
  output logic [7:0] event_c
);
  // peripherals raise one-cycle condition pulses, aligned to hclk
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      {event_a, event_b, event_c} <= 24'h00_0000;
    else
      {event_a, event_b, event_c} <= fire;
  end
endmodule : pib_periph_model

// ==== sim/tb_pib_irq_bank.sv ====
`timescale 1ns/10ps
module tb_pib_irq_bank;
  import pib_pkg::*;
  logic hclk = 0;
  logic hresetn = 0;
  logic hsel = 0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic hreadyout, hresp, periph_irq, core_irq;
  logic [23:0] fire = 24'h00_0000;
  logic [7:0] ev_a, ev_b, ev_c;
  int n_errors = 0;
  int cmp_count = 0;
  logic [4:0] offs [7] = '{PIB_OFF_EN_A, PIB_OFF_EN_B, PIB_OFF_EN_C, PIB_OFF_RQ_A, PIB_OFF_RQ_B,
    PIB_OFF_RQ_C, PIB_OFF_CORE};
  // rx/tx request flags never take a software one
  logic [7:0] msk [7] = '{8'hff, 8'hfd, 8'h7a, 8'hcf, 8'hfd, 8'h7a, 8'hc0};
  pib_irq_bank uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .event_a(ev_a), .event_b(ev_b), .event_c(ev_c),
    .periph_irq(periph_irq), .core_irq(core_irq));
  pib_periph_model pm (.hclk(hclk), .hresetn(hresetn), .fire(fire), .event_a(ev_a), .event_b(ev_b),
    .event_c(ev_c));
  initial
  begin
    forever #25 hclk = ~hclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {27'h000_0000, a};
    hwrite <= w;
    htrans <= PIB_HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : xfer
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rc(input logic [4:0] a, input logic [7:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0000_0000, q);
    chk(q, {24'h00_0000, e});
  endtask : rc
  task automatic irq_chk(input logic p, input logic c);
    @(posedge hclk);
    chk({30'h0000_0000, periph_irq, core_irq}, {30'h0000_0000, p, c});
  endtask : irq_chk
  task automatic close_out;
    $display("counts: %0d compares, %0d mismatches", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out
  initial
  begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 7; i++)
    begin
      rc(offs[i], 8'h00);
      wr(offs[i], 32'hffff_ffff);
      rc(offs[i], msk[i]);
      wr(offs[i], 32'h0000_0000);
      rc(offs[i], 8'h00);
    end
    $display("test register access done");
    for (int i = 0; i < 3; i++)
      wr(offs[i], 32'h0000_00ff);
    @(posedge hclk);
    fire <= 24'hff_ffff;
    @(posedge hclk);
    fire <= 24'h00_0000;
    repeat (2) @(posedge hclk);
    for (int i = 3; i < 6; i++)
      rc(offs[i], msk[i] | ((i == 3) ? 8'h30 : 8'h00));
    irq_chk(1'b0, 1'b0);
    wr(PIB_OFF_CORE, 32'h0000_0040);
    irq_chk(1'b1, 1'b0);
    wr(PIB_OFF_CORE, 32'h0000_00c0);
    irq_chk(1'b1, 1'b1);
    for (int i = 3; i < 6; i++)
      wr(offs[i], 32'h0000_0000);
    rc(PIB_OFF_RQ_A, 8'h30);
    irq_chk(1'b1, 1'b1);
    wr(PIB_OFF_EN_A, 32'h0000_00cf);
    irq_chk(1'b0, 1'b0);
    $display("test interrupt path done");
    fork
      wr(PIB_OFF_RQ_C, 32'h0000_0000);
      begin
        @(posedge hclk);
        fire <= 24'h00_0010;
        @(posedge hclk);
        fire <= 24'h00_0000;
      end
    join
    rc(PIB_OFF_RQ_C, 8'h10);
    irq_chk(1'b1, 1'b1);
    $display("test set against clear done");
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 7; i++)
      rc(offs[i], 8'h00);
    irq_chk(1'b0, 1'b0);
    $display("test mid-run reset done");
    close_out();
  end
  initial
  begin
    repeat (5000) @(posedge hclk);
    n_errors++;
    close_out();
  end
endmodule : tb_pib_irq_bank

// ==== src/pib_irq_bank.sv ====
`timescale 1ns/10ps
module pib_irq_bank
  import pib_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [7:0] event_a,
  input wire logic [7:0] event_b,
  input wire logic [7:0] event_c,
  output logic periph_irq,
  output logic core_irq
);
  logic [7:0] en_a_reg, en_b_reg, en_c_reg;
  logic [7:0] rq_a_reg, rq_b_reg, rq_c_reg;
  logic [7:0] core_reg;
  logic wr_pend_reg;
  logic [PIB_AW-1:0] wr_addr_reg;
  logic [31:0] hrdata_reg;
  logic periph_irq_reg, core_irq_reg;
  logic hreadyout_reg, hresp_reg;
  localparam int REG_W = 8;

  function automatic logic [7:0] sel_word(input logic [PIB_AW-1:0] a, input logic [PIB_AW-1:0] off);
    sel_word = (a == off) ? 8'hff : 8'h00;
  endfunction : sel_word

  wire logic addr_ok = hsel && hready && (htrans == PIB_HTRANS_NONSEQ || htrans == PIB_HTRANS_SEQ);
  wire logic rd_go = addr_ok && !hwrite;
  wire logic wr_go = addr_ok && hwrite;
  wire logic [PIB_AW-1:0] ra = haddr[PIB_AW-1:0];
  wire logic [7:0] wd = hwdata[7:0];
  wire logic [7:0] w_en_a = wr_pend_reg ? sel_word(wr_addr_reg, PIB_OFF_EN_A) : 8'h00;
  wire logic [7:0] w_en_b = wr_pend_reg ? sel_word(wr_addr_reg, PIB_OFF_EN_B) : 8'h00;
  wire logic [7:0] w_en_c = wr_pend_reg ? sel_word(wr_addr_reg, PIB_OFF_EN_C) : 8'h00;
  wire logic [7:0] w_rq_a = wr_pend_reg ? sel_word(wr_addr_reg, PIB_OFF_RQ_A) : 8'h00;
  wire logic [7:0] w_rq_b = wr_pend_reg ? sel_word(wr_addr_reg, PIB_OFF_RQ_B) : 8'h00;
  wire logic [7:0] w_rq_c = wr_pend_reg ? sel_word(wr_addr_reg, PIB_OFF_RQ_C) : 8'h00;
  wire logic [7:0] w_core = wr_pend_reg ? sel_word(wr_addr_reg, PIB_OFF_CORE) : 8'h00;

  // enables: masked writes keep unimplemented bits at zero
  wire logic [7:0] en_a_next = (en_a_reg & ~w_en_a) | (wd & w_en_a & PIB_MASK_A);
  wire logic [7:0] en_b_next = (en_b_reg & ~w_en_b) | (wd & w_en_b & PIB_MASK_B);
  wire logic [7:0] en_c_next = (en_c_reg & ~w_en_c) | (wd & w_en_c & PIB_MASK_C);
  wire logic [7:0] core_next = (core_reg & ~w_core) | (wd & w_core & PIB_MASK_CORE);

  // flags: software value where written, then events OR'd in so a set beats a clear
  wire logic [7:0] wm_a = w_rq_a & PIB_WMASK_RQ_A;
  wire logic [7:0] rq_a_next = ((rq_a_reg & ~wm_a) | (wd & wm_a) | event_a) & PIB_MASK_A;
  wire logic [7:0] rq_b_next = ((rq_b_reg & ~w_rq_b) | (wd & w_rq_b) | event_b) & PIB_MASK_B;
  wire logic [7:0] rq_c_next = ((rq_c_reg & ~w_rq_c) | (wd & w_rq_c) | event_c) & PIB_MASK_C;

  // request uses next-state values so the output flop tracks the registers exactly
  wire logic any_hit = |((rq_a_next & en_a_next) | (rq_b_next & en_b_next) | (rq_c_next & en_c_next));
  wire logic periph_next = any_hit && core_next[PIB_BIT_PERIPH_IRQ_EN];
  wire logic core_irq_next = periph_next && core_next[PIB_BIT_GIE];

  logic [7:0] rd_byte;
  always_comb
  begin
    case (ra)
      PIB_OFF_EN_A: rd_byte = en_a_next;
      PIB_OFF_EN_B: rd_byte = en_b_next;
      PIB_OFF_EN_C: rd_byte = en_c_next;
      PIB_OFF_RQ_A: rd_byte = rq_a_next;
      PIB_OFF_RQ_B: rd_byte = rq_b_next;
      PIB_OFF_RQ_C: rd_byte = rq_c_next;
      PIB_OFF_CORE: rd_byte = core_next;
      default: rd_byte = PIB_RST8; // unmapped reads zero, OKAY
    endcase
  end

  // bus side: write strobe and address wait one cycle for the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
      hrdata_reg <= PIB_RST32;
      hreadyout_reg <= 1'b1;
      hresp_reg <= 1'b0;
    end
    else
    begin
      wr_pend_reg <= wr_go;
      wr_addr_reg <= ra;
      hrdata_reg <= rd_go ? {24'h00_0000, rd_byte} : PIB_RST32;
      hreadyout_reg <= 1'b1; // never stalls, so every transfer is two cycles
      hresp_reg <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      en_a_reg <= PIB_RST8;
      en_b_reg <= PIB_RST8;
      en_c_reg <= PIB_RST8;
      core_reg <= PIB_RST8;
    end
    else
    begin
      en_a_reg <= en_a_next;
      en_b_reg <= en_b_next;
      en_c_reg <= en_c_next;
      core_reg <= core_next;
    end
  end

  // flags never wait on the enables; gating happens at the request flops
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rq_a_reg <= PIB_RST8;
      rq_b_reg <= PIB_RST8;
      rq_c_reg <= PIB_RST8;
    end
    else
    begin
      rq_a_reg <= rq_a_next;
      rq_b_reg <= rq_b_next;
      rq_c_reg <= rq_c_next;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      periph_irq_reg <= 1'b0;
      core_irq_reg <= 1'b0;
    end
    else
    begin
      periph_irq_reg <= periph_next;
      core_irq_reg <= core_irq_next;
    end
  end

  assign hrdata = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp = hresp_reg;
  assign periph_irq = periph_irq_reg;
  assign core_irq = core_irq_reg;

  chk_periph_irq_en_gates_req: assert property (@(posedge hclk) disable iff (!hresetn)
    !core_reg[PIB_BIT_PERIPH_IRQ_EN] |-> !periph_irq) else $error("request while peripheral enable clear");
  chk_event_sets_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    event_b[0] |=> rq_b_reg[0]) else $error("event did not set flag");
  chk_rx_flag_readonly: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_pend_reg && wr_addr_reg == PIB_OFF_RQ_A && !event_a[5] && rq_a_reg[5]) |=> rq_a_reg[5])
    else $error("rx flag cleared by software");
  chk_unimpl_b_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    !en_b_reg[1] && !rq_b_reg[1]) else $error("unimplemented bit set");
  chk_unimpl_c_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    (en_c_reg & ~PIB_MASK_C) == 8'h00 && (rq_c_reg & ~PIB_MASK_C) == 8'h00) else $error("bank c reserved set");
  chk_req_follows: assert property (@(posedge hclk) disable iff (!hresetn)
    periph_irq == (core_reg[PIB_BIT_PERIPH_IRQ_EN] && |((rq_a_reg & en_a_reg) | (rq_b_reg & en_b_reg)
    | (rq_c_reg & en_c_reg)))) else $error("request mismatch");
  chk_gie_gates_core: assert property (@(posedge hclk) disable iff (!hresetn)
    core_irq == (periph_irq && core_reg[PIB_BIT_GIE])) else $error("core request mismatch");
  chk_set_beats_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_pend_reg && wr_addr_reg == PIB_OFF_RQ_C && !hwdata[4] && event_c[4]) |=> rq_c_reg[4])
    else $error("clear beat set");
  chk_write_clears: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_pend_reg && wr_addr_reg == PIB_OFF_RQ_A && !hwdata[0] && !event_a[0]) |=> !rq_a_reg[0])
    else $error("flag write zero did not clear");
  chk_enable_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_pend_reg && wr_addr_reg == PIB_OFF_EN_A) |=> en_a_reg == $past(hwdata[7:0]))
    else $error("enable write lost");
  cov_irq_raise: cover property (@(posedge hclk) disable iff (!hresetn) $rose(periph_irq));
  cov_core_irq: cover property (@(posedge hclk) disable iff (!hresetn) core_irq);
  cov_set_clear_race: cover property (@(posedge hclk) disable iff (!hresetn)
    wr_pend_reg && wr_addr_reg == PIB_OFF_RQ_C && event_c[4]);
  cov_rx_sticky: cover property (@(posedge hclk) disable iff (!hresetn)
    wr_pend_reg && wr_addr_reg == PIB_OFF_RQ_A && rq_a_reg[5]);
  cov_core_masked: cover property (@(posedge hclk) disable iff (!hresetn) periph_irq && !core_irq);

  // checked at release, where the reset values are still in view
  chk_reset_clear: assert property (@(posedge hclk) $rose(hresetn) |->
    (en_a_reg | en_b_reg | en_c_reg | rq_a_reg | rq_b_reg | rq_c_reg | core_reg) == PIB_RST8
    && hrdata == PIB_RST32 && !periph_irq && !core_irq) else $error("state not cleared by reset");

  chk_en_b_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_pend_reg && wr_addr_reg == PIB_OFF_EN_B) |=> en_b_reg == ($past(wd) & PIB_MASK_B))
    else $error("enable b write wrong");
  chk_en_c_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_pend_reg && wr_addr_reg == PIB_OFF_EN_C) |=> en_c_reg == ($past(wd) & PIB_MASK_C))
    else $error("enable c write wrong");
  chk_core_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_pend_reg && wr_addr_reg == PIB_OFF_CORE) |=> core_reg == ($past(wd) & PIB_MASK_CORE))
    else $error("core control write wrong");
  chk_en_a_top: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_pend_reg && wr_addr_reg == PIB_OFF_EN_A) |=> en_a_reg[7:6] == $past(wd[7:6]))
    else $error("gate or adc enable lost");

  // read data is the next-state byte, so it equals the register one edge later
  chk_read_en_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_go && ra == PIB_OFF_EN_A) |=> hrdata == {24'h00_0000, en_a_reg}) else $error("enable a read wrong");
  chk_read_en_b: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_go && ra == PIB_OFF_EN_B) |=> hrdata == {24'h00_0000, en_b_reg}) else $error("enable b read wrong");
  chk_read_en_c: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_go && ra == PIB_OFF_EN_C) |=> hrdata == {24'h00_0000, en_c_reg}) else $error("enable c read wrong");
  chk_read_rq_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_go && ra == PIB_OFF_RQ_A) |=> hrdata == {24'h00_0000, rq_a_reg}) else $error("request a read wrong");
  chk_read_rq_b: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_go && ra == PIB_OFF_RQ_B) |=> hrdata == {24'h00_0000, rq_b_reg}) else $error("request b read wrong");
  chk_read_rq_c: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_go && ra == PIB_OFF_RQ_C) |=> hrdata == {24'h00_0000, rq_c_reg}) else $error("request c read wrong");
  chk_read_core: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_go && ra == PIB_OFF_CORE) |=> hrdata == {24'h00_0000, core_reg}) else $error("core read wrong");
  chk_idle_read_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    !rd_go |=> hrdata == PIB_RST32) else $error("read data left standing");

  chk_gie_off_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
    !core_reg[PIB_BIT_GIE] |-> !core_irq) else $error("core request while global enable clear");
  chk_periph_irq_en_core_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
    !core_reg[PIB_BIT_PERIPH_IRQ_EN] |-> !core_irq) else $error("core request while peripheral enable clear");
  chk_hit_raises: assert property (@(posedge hclk) disable iff (!hresetn)
    (core_reg[PIB_BIT_PERIPH_IRQ_EN] && |(rq_a_reg & en_a_reg)) |-> periph_irq) else $error("enabled flag not requested");
  chk_bus_okay: assert property (@(posedge hclk) disable iff (!hresetn)
    hreadyout && !hresp) else $error("bus answer not ready and okay");
  chk_core_rsvd_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    (core_reg & ~PIB_MASK_CORE) == PIB_RST8) else $error("core reserved bit set");

  // a set of checkers per flag slot; reserved slots must stay dark whatever is written
  for (genvar gi = 0; gi < REG_W; gi++)
  begin : g_bit_chk
    chk_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
      event_a[gi] |=> rq_a_reg[gi]) else $error("bank a flag missed its event");
    chk_race_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (wr_pend_reg && wr_addr_reg == PIB_OFF_RQ_A && event_a[gi]) |=> rq_a_reg[gi])
      else $error("bank a clear beat its event");
    if (PIB_WMASK_RQ_A[gi])
    begin : g_wa
      chk_clr_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_pend_reg && wr_addr_reg == PIB_OFF_RQ_A && !wd[gi] && !event_a[gi]) |=> !rq_a_reg[gi])
        else $error("bank a flag not cleared");
    end
    else
    begin : g_ra
      chk_ro_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_pend_reg && wr_addr_reg == PIB_OFF_RQ_A && !event_a[gi]) |=> rq_a_reg[gi] == $past(rq_a_reg[gi]))
        else $error("read-only flag moved by a write");
    end
    if (PIB_MASK_B[gi])
    begin : g_b
      chk_set_b: assert property (@(posedge hclk) disable iff (!hresetn)
        event_b[gi] |=> rq_b_reg[gi]) else $error("bank b flag missed its event");
      chk_race_b: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_pend_reg && wr_addr_reg == PIB_OFF_RQ_B && event_b[gi]) |=> rq_b_reg[gi])
        else $error("bank b clear beat its event");
      chk_clr_b: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_pend_reg && wr_addr_reg == PIB_OFF_RQ_B && !wd[gi] && !event_b[gi]) |=> !rq_b_reg[gi])
        else $error("bank b flag not cleared");
    end
    else
    begin : g_bz
      chk_rsvd_b: assert property (@(posedge hclk) disable iff (!hresetn)
        !rq_b_reg[gi] && !en_b_reg[gi]) else $error("bank b reserved slot set");
    end
    if (PIB_MASK_C[gi])
    begin : g_c
      chk_set_c: assert property (@(posedge hclk) disable iff (!hresetn)
        event_c[gi] |=> rq_c_reg[gi]) else $error("bank c flag missed its event");
      chk_race_c: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_pend_reg && wr_addr_reg == PIB_OFF_RQ_C && event_c[gi]) |=> rq_c_reg[gi])
        else $error("bank c clear beat its event");
      chk_clr_c: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_pend_reg && wr_addr_reg == PIB_OFF_RQ_C && !wd[gi] && !event_c[gi]) |=> !rq_c_reg[gi])
        else $error("bank c flag not cleared");
    end
    else
    begin : g_cz
      chk_rsvd_c: assert property (@(posedge hclk) disable iff (!hresetn)
        !rq_c_reg[gi] && !en_c_reg[gi]) else $error("bank c reserved slot set");
    end
  end
endmodule : pib_irq_bank

// ==== src/pib_pkg.sv ====
package pib_pkg;
  localparam int PIB_AW = 5;
  // register byte offsets, one aligned word each
  localparam logic [PIB_AW-1:0] PIB_OFF_EN_A = 5'h00;
  localparam logic [PIB_AW-1:0] PIB_OFF_EN_B = 5'h04;
  localparam logic [PIB_AW-1:0] PIB_OFF_EN_C = 5'h08;
  localparam logic [PIB_AW-1:0] PIB_OFF_RQ_A = 5'h0c;
  localparam logic [PIB_AW-1:0] PIB_OFF_RQ_B = 5'h10;
  localparam logic [PIB_AW-1:0] PIB_OFF_RQ_C = 5'h14;
  localparam logic [PIB_AW-1:0] PIB_OFF_CORE = 5'h18;
  // implemented-bit masks
  localparam logic [7:0] PIB_MASK_A = 8'hff;
  localparam logic [7:0] PIB_MASK_B = 8'hfd;
  localparam logic [7:0] PIB_MASK_C = 8'h7a;
  // software-writable request bits; rx/tx flags are read-only
  localparam logic [7:0] PIB_WMASK_RQ_A = 8'hcf;
  // core control bits
  localparam int PIB_BIT_GIE = 7;
  localparam int PIB_BIT_PERIPH_IRQ_EN = 6;
  localparam logic [7:0] PIB_MASK_CORE = 8'hc0;
  localparam logic [7:0] PIB_RST8 = 8'h00;
  localparam logic [31:0] PIB_RST32 = 32'h0000_0000;
  localparam logic [1:0] PIB_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] PIB_HTRANS_SEQ = 2'h3;
endpackage : pib_pkg
